// [rtl/sec_map.svh]
// constants of the serial eeprom slave
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH
`define SEC_CTRL_CODE 4'ha
`define SEC_CACHE_BYTES 64
`define SEC_PAGE_BYTES 8
`define SEC_MEM_DEPTH 4096
`define SEC_FIFO_DEPTH 8
`define SEC_FIFO_W 24
`define SEC_TMR_W 24
`define SEC_CLK_NS 25
`define SEC_T_PROG_MS 5
`define SEC_PROG_CYC (`SEC_T_PROG_MS * 1000000 / `SEC_CLK_NS)
`endif

// [rtl/sec_pkg.sv]
// types of the serial eeprom slave
`include "sec_map.svh"
package sec_pkg;
  typedef enum {ST_IDLE, ST_CTRL, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA, ST_PROG} sec_st_t;
  typedef struct packed {
    sec_st_t st;
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic [2:0] cs_s1;
    logic [2:0] cs_s2;
    logic vl_s1;
    logic vl_s2;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic mack;
    logic [15:0] ptr;
    logic [15:0] start;
    logic [5:0] wptr;
    logic [63:0] mask;
    logic [63:0][7:0] cache;
    logic any;
    logic [2:0] pg;
    logic [3:0] pidx;
    logic [`SEC_TMR_W-1:0] tmr;
    logic sda_oe;
    logic busy;
    logic standby;
    logic vmon;
  } sec_state_t;
endpackage

// [rtl/sec_fifo.sv]
// fifo between cache drain and array write port
module sec_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sec_fifo_st_t;
  sec_fifo_st_t q, n;
  logic push, pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction

  assign o_ready = (q.cnt != (AW + 1)'(D));
  assign o_valid = (q.cnt != '0);
  assign o_data = q.mem[q.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = i_data;
      n.wp = nxt(q.wp);
    end
    if (pop) begin
      n.rp = nxt(q.rp);
    end
    n.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q.wp <= '0;
      q.rp <= '0;
      q.cnt <= '0;
      q.mem <= q.mem;
    end else begin
      q <= n;
    end
  end
endmodule

// [rtl/sec_mem.sv]
// byte array with one write and one read port
module sec_mem #(
  parameter int DEPTH = 4096,
  parameter int AW = 16
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  localparam int IW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] arr;
  } sec_mem_st_t;
  sec_mem_st_t q, n;

  function automatic logic in_range(input logic [AW-1:0] a);
    in_range = (32'(a) < DEPTH);
  endfunction

  // unused space reads as erased
  assign o_rdata = in_range(i_raddr) ? q.arr[i_raddr[IW-1:0]] : 8'hff;

  always_comb begin
    n = q;
    if (i_we && in_range(i_waddr)) begin
      n.arr[i_waddr[IW-1:0]] = i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= n;
  end
endmodule

// [rtl/sec_eeprom.sv]
// two-wire serial eeprom slave with page cache and timed programming
// Operation
// - first byte after start: type code 1010, three select bits, read/write bit
// - no acknowledge driven while programming runs
// - each master acknowledge on read yields the next sequential byte
// - address pointer increments after every byte
// - pointer passes the top address into unused space, never wraps
// - sixty-four byte cache, eight pages of eight bytes
// - cache loads until stop, then programming starts
// - one fixed program interval per loaded page, partial or full
// - cache pointer wraps to page zero byte zero after cache byte 63
// - bus ignored entirely while programming
// - aligned writes program sequential array addresses across block boundary
// - separate program interval after each page transfer
// - first byte lands in cache page zero at address low bits
// - cache fill from mid page wraps into leading bytes of page zero
// - page zero goes to addressed array page, others follow in order
// - only received bytes of a partial page are programmed
// - standby after stop and idle, or after an aborted transfer
// - low supply blocks array writes; monitor off in standby
// - answer only when select bits match the strapped pins
// - data line changes only while clock is low
// - data line is open drain, pulled low only
`include "sec_map.svh"
module sec_eeprom
  import sec_pkg::*;
#(
  parameter int unsigned PROG_CYC = `SEC_PROG_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_SDA_IN,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  input wire logic I_CHIP_SELECT_PIN_0,
  input wire logic I_CHIP_SELECT_PIN_1,
  input wire logic I_CHIP_SELECT_PIN_2,
  input wire logic I_LOW_VDD,
  output logic O_BUSY,
  output logic O_STANDBY,
  output logic O_VMON_EN
);
  // ****************************************
  // declarations
  // ****************************************
  sec_state_t q, n;
  logic rise, fall, start, stop, sda_s, rx_done;
  logic page_has, bit_has, push_v, push_rdy;
  logic pop_v, pop_rdy, mem_we;
  logic [15:0] push_addr;
  logic [7:0] mem_rd;
  logic [`SEC_FIFO_W-1:0] push_d, pop_d;

  assign sda_s = q.sda_s2;
  assign rise = q.scl_s2 && !q.scl_p;
  assign fall = !q.scl_s2 && q.scl_p;
  assign start = q.scl_s2 && q.scl_p && !q.sda_s2 && q.sda_p;
  assign stop = q.scl_s2 && q.scl_p && q.sda_s2 && !q.sda_p;
  assign rx_done = fall && q.bcnt == 4'h7 && q.st != ST_RDATA && q.st != ST_IDLE && q.st != ST_PROG;

  // ****************************************
  // cache drain to array
  // ****************************************
  assign page_has = |q.mask[{q.pg, 3'h0} +: 8];
  assign bit_has = q.mask[{q.pg, q.pidx[2:0]}];
  assign push_v = q.st == ST_PROG && page_has && !q.pidx[3] && bit_has;
  assign push_addr = {q.start[15:3], 3'h0} + {10'h000, q.pg, q.pidx[2:0]};
  assign push_d = {push_addr, q.cache[{q.pg, q.pidx[2:0]}]};
  assign pop_rdy = q.busy;
  assign mem_we = pop_v && pop_rdy && !(q.vl_s2 && q.vmon);

  sec_fifo #(
    .W(`SEC_FIFO_W),
    .D(`SEC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_valid(push_v),
    .o_ready(push_rdy),
    .i_data(push_d),
    .o_valid(pop_v),
    .i_ready(pop_rdy),
    .o_data(pop_d)
  );

  sec_mem #(
    .DEPTH(`SEC_MEM_DEPTH),
    .AW(16)
  ) u_mem (
    .i_clk(I_CLK),
    .i_we(mem_we),
    .i_waddr(pop_d[23:8]),
    .i_wdata(pop_d[7:0]),
    .i_raddr(q.ptr),
    .o_rdata(mem_rd)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = q;
    n.scl_s1 = I_SCL;
    n.scl_s2 = q.scl_s1;
    n.scl_p = q.scl_s2;
    n.sda_s1 = I_SDA_IN;
    n.sda_s2 = q.sda_s1;
    n.sda_p = q.sda_s2;
    n.cs_s1 = {I_CHIP_SELECT_PIN_2, I_CHIP_SELECT_PIN_1, I_CHIP_SELECT_PIN_0};
    n.cs_s2 = q.cs_s1;
    n.vl_s1 = I_LOW_VDD;
    n.vl_s2 = q.vl_s1;
    if (q.st == ST_PROG) begin
      n.sda_oe = 1'b0;
      if (!page_has || (q.pidx[3] && q.tmr == `SEC_TMR_W'(PROG_CYC - 1))) begin
        n.tmr = '0;
        n.pidx = '0;
        n.pg = q.pg + 3'h1;
        if (q.pg == 3'h7) begin
          n.st = ST_IDLE;
          n.any = 1'b0;
          n.mask = '0;
        end
      end else if (!q.pidx[3]) begin
        if (!bit_has || push_rdy) begin
          n.pidx = q.pidx + 4'h1;
        end
      end else begin
        n.tmr = q.tmr + `SEC_TMR_W'(1);
      end
    end else if (start) begin
      n.st = ST_CTRL;
      // first clock fall after start is not a data bit
      n.bcnt = 4'h8;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.sda_oe = 1'b0;
      n.bcnt = '0;
      n.pg = '0;
      n.pidx = '0;
      n.tmr = '0;
      n.st = (q.st == ST_WDATA && q.any) ? ST_PROG : ST_IDLE;
    end else if (q.st != ST_IDLE) begin
      if (rise && !q.bcnt[3]) begin
        n.sh = {q.sh[6:0], sda_s};
      end
      if (rise && q.bcnt[3] && q.st == ST_RDATA && !q.sda_oe) begin
        n.mack = !sda_s;
      end
      if (fall) begin
        if (q.st == ST_RDATA) begin
          if (q.bcnt[3]) begin
            if (q.mack) begin
              n.tx = mem_rd;
              n.sda_oe = !mem_rd[7];
              n.ptr = q.ptr + 16'h0001;
              n.bcnt = '0;
            end else begin
              n.st = ST_IDLE;
              n.sda_oe = 1'b0;
            end
          end else if (q.bcnt == 4'h7) begin
            n.sda_oe = 1'b0;
            n.bcnt = 4'h8;
          end else begin
            n.tx = {q.tx[6:0], 1'b0};
            n.sda_oe = !q.tx[6];
            n.bcnt = q.bcnt + 4'h1;
          end
        end else if (q.bcnt[3]) begin
          n.sda_oe = 1'b0;
          n.bcnt = '0;
        end else if (rx_done) begin
          n.bcnt = 4'h8;
          n.sda_oe = 1'b1;
          case (q.st)
            ST_CTRL: begin
              if (q.sh[7:4] == `SEC_CTRL_CODE && q.sh[3:1] == q.cs_s2) begin
                if (q.sh[0]) begin
                  n.st = ST_RDATA;
                  n.mack = 1'b1;
                end else begin
                  n.st = ST_AHI;
                end
              end else begin
                n.st = ST_IDLE;
                n.sda_oe = 1'b0;
                n.bcnt = '0;
              end
            end
            ST_AHI: begin
              n.ptr[15:8] = q.sh;
              n.st = ST_ALO;
            end
            ST_ALO: begin
              n.ptr[7:0] = q.sh;
              n.start = {q.ptr[15:8], q.sh};
              n.wptr = {3'h0, q.sh[2:0]};
              n.mask = '0;
              n.any = 1'b0;
              n.st = ST_WDATA;
            end
            ST_WDATA: begin
              n.cache[q.wptr] = q.sh;
              n.mask[q.wptr] = 1'b1;
              n.wptr = q.wptr + 6'h01;
              n.ptr = q.ptr + 16'h0001;
              n.any = 1'b1;
            end
            default: begin
              n.sda_oe = 1'b0;
            end
          endcase
        end else begin
          n.bcnt = q.bcnt + 4'h1;
        end
      end
    end
    n.busy = n.st == ST_PROG;
    n.standby = n.st == ST_IDLE;
    n.vmon = !n.standby;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_p <= 1'b1;
      q.standby <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE = q.sda_oe;
  assign O_BUSY = q.busy;
  assign O_STANDBY = q.standby;
  assign O_VMON_EN = q.vmon;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_low_only;
    O_SDA_OUT == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("data line driven high");

  property p_quiet_prog;
    O_BUSY |-> !O_SDA_OE;
  endproperty
  a_quiet_prog: assert property (p_quiet_prog) else $error("ack driven while busy");

  property p_ignore_bus;
    q.st == ST_PROG && start |=> q.st != ST_CTRL;
  endproperty
  a_ignore_bus: assert property (p_ignore_bus) else $error("command taken while busy");

  property p_change_low;
    $changed(O_SDA_OE) |-> !q.scl_p;
  endproperty
  a_change_low: assert property (p_change_low) else $error("data changed with clock high");

  property p_seq_read;
    q.st == ST_RDATA && fall && q.bcnt[3] && q.mack |=> q.ptr == $past(q.ptr) + 16'h0001;
  endproperty
  a_seq_read: assert property (p_seq_read) else $error("pointer not advanced on read");

  property p_no_wrap;
    q.ptr == 16'h07ff && q.st == ST_RDATA && fall && q.bcnt[3] && q.mack |=> q.ptr == 16'h0800;
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("pointer wrapped");

  property p_cache_wrap;
    rx_done && q.st == ST_WDATA && q.wptr == 6'h3f |=> q.wptr == 6'h00;
  endproperty
  a_cache_wrap: assert property (p_cache_wrap) else $error("cache pointer did not wrap");

  property p_first_page;
    rx_done && q.st == ST_ALO |=> q.wptr[5:3] == 3'h0 && q.wptr[2:0] == $past(q.sh[2:0]);
  endproperty
  a_first_page: assert property (p_first_page) else $error("first byte not in page zero");

  property p_stop_prog;
    stop && q.st == ST_WDATA && q.any |=> O_BUSY ##1 O_BUSY;
  endproperty
  a_stop_prog: assert property (p_stop_prog) else $error("no program after stop");

  property p_select;
    rx_done && q.st == ST_CTRL && q.sh[3:1] != q.cs_s2 |=> q.st == ST_IDLE && !O_SDA_OE;
  endproperty
  a_select: assert property (p_select) else $error("answered foreign select");

  property p_low_block;
    mem_we |-> !q.vl_s2 && O_VMON_EN;
  endproperty
  a_low_block: assert property (p_low_block) else $error("write under low supply");

  property p_interval;
    q.st == ST_PROG && q.pidx[3] |-> q.tmr < `SEC_TMR_W'(PROG_CYC);
  endproperty
  a_interval: assert property (p_interval) else $error("interval overrun");

  property p_standby;
    q.st == ST_IDLE |=> O_STANDBY || q.st != ST_IDLE;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby when idle");

  c_seq_read: cover property (q.st == ST_RDATA && fall && q.bcnt[3] && q.mack ##[1:1000] q.st == ST_RDATA && q.tx != 8'h00);
  c_prog: cover property (stop && q.st == ST_WDATA && q.any);
  c_wrap: cover property (rx_done && q.st == ST_WDATA && q.wptr == 6'h3f);
  c_written: cover property (mem_we);
endmodule

// [bench/sec_bus_master.sv]
// two-wire bus master model driving the eeprom bench
module sec_bus_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // bus primitives
  // ****************
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // data set only while clock low
  task automatic bit_io(input logic b, output logic s);
    o_scl <= 1'b0;
    tick(2);
    o_sda_oe <= ~b;
    tick(6);
    o_scl <= 1'b1;
    tick(4);
    s = i_sda;
    tick(4);
  endtask
  task automatic start();
    o_scl <= 1'b0;
    tick(2);
    o_sda_oe <= 1'b0;
    tick(6);
    o_scl <= 1'b1;
    tick(8);
    o_sda_oe <= 1'b1;
    tick(8);
  endtask
  task automatic stop();
    o_scl <= 1'b0;
    tick(2);
    o_sda_oe <= 1'b1;
    tick(6);
    o_scl <= 1'b1;
    tick(8);
    o_sda_oe <= 1'b0;
    tick(8);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // last byte gets no acknowledge
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
  // select bits carry system address bits 14..12
  task automatic cmd(input logic [14:0] sa, input logic rd, output logic ack);
    logic a;
    start();
    put({4'ha, sa[14:12], rd}, a);
    ack = a;
    if (a && !rd) begin
      put({4'h0, sa[11:8]}, a);
      ack = ack & a;
      put(sa[7:0], a);
      ack = ack & a;
    end
  endtask
endmodule

// [bench/sec_eeprom_tb_top.sv]
// self-checking bench of the serial eeprom slave
module sec_eeprom_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 30;
  logic clk;
  logic rst_n;
  logic scl;
  logic m_oe;
  logic sda_out;
  logic sda_oe;
  logic [2:0] pins;
  logic low_vdd;
  logic busy;
  logic standby;
  logic vmon;
  logic sda;
  logic scl_q;
  logic oe_q;
  logic [7:0] exp_mem [0:4095];
  int fail_count;
  int total_checks;
  assign sda = ~(m_oe | sda_oe);
  sec_eeprom #(.PROG_CYC(P)) i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA_IN(sda),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_CHIP_SELECT_PIN_0(pins[0]),
    .I_CHIP_SELECT_PIN_1(pins[1]), .I_CHIP_SELECT_PIN_2(pins[2]), .I_LOW_VDD(low_vdd),
    .O_BUSY(busy), .O_STANDBY(standby), .O_VMON_EN(vmon));
  sec_bus_master i_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  // ****************
  // helpers
  // ****************
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        check("busy_wait", 16'h0001, 16'h0000);
        final_report();
      end
    end
  endtask
  always @(posedge clk) begin
    scl_q <= scl;
    oe_q <= sda_oe;
    if (scl && scl_q && sda_oe !== oe_q) check("sda_oe_scl_high", sda_oe, oe_q);
    if (sda_oe && sda_out !== 1'b0) check("sda_open_drain", sda_out, 1'b0);
  end
  task automatic wr(input logic [14:0] sa, input logic [7:0] q[$], input logic poll);
    logic [7:0] c [64];
    logic [63:0] m;
    logic ack;
    int k;
    int n;
    int pg;
    m = '0;
    pg = 0;
    i_mst.cmd(sa, 1'b0, ack);
    check("write_ack", ack, 1'b1);
    foreach (q[i]) begin
      i_mst.put(q[i], ack);
      k = (sa[2:0] + i) % 64;
      c[k] = q[i];
      m[k] = 1'b1;
    end
    i_mst.stop();
    check("busy_after_stop", {busy, standby, vmon}, 3'h5);
    for (int i = 0; i < 64; i++) begin
      if (m[i] && !low_vdd) exp_mem[{sa[11:3], 3'h0} + i] = c[i];
    end
    for (int p = 0; p < 8; p++) begin
      pg += int'(m[p*8 +: 8] != 8'h00);
    end
    if (poll) begin
      i_mst.cmd(sa, 1'b0, ack);
      check("poll_no_ack", ack, 1'b0);
      i_mst.stop();
    end
    wait_idle(n);
    if (!poll) check("prog_time", n >= pg * P - 10 && n <= pg * P + 40, 1'b1);
    i_mst.tick(2);
    check("standby_idle", {busy, standby, vmon}, 3'h2);
  endtask
  task automatic rd(input logic [14:0] sa, input int n);
    logic ack;
    logic [7:0] d;
    logic [15:0] ad;
    i_mst.cmd(sa, 1'b0, ack);
    i_mst.cmd(sa, 1'b1, ack);
    check("read_ack", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_mst.get(i == n - 1, d);
      ad = {4'h0, sa[11:0]} + 16'(i);
      check("read_data", d, ad < 16'h1000 ? exp_mem[ad] : 8'hff);
    end
    i_mst.stop();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    check("reset_outputs", {sda_oe, busy, standby, vmon}, 4'h2);
    $display("test reset done");
  endtask
  task automatic t_select();
    logic ack;
    pins <= 3'h2;
    i_mst.tick(4);
    i_mst.cmd(15'h5000, 1'b1, ack);
    check("wrong_select_ack", ack, 1'b0);
    i_mst.tick(10);
    check("standby_abort", standby, 1'b1);
    i_mst.start();
    i_mst.put(8'hb4, ack);
    check("wrong_code_ack", ack, 1'b0);
    i_mst.stop();
    pins <= 3'h5;
    i_mst.tick(4);
    $display("test select done");
  endtask
  task automatic t_page();
    wr(15'h5200, '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7}, 1'b0);
    wr(15'h5203, '{8'h11, 8'h22}, 1'b0);
    rd(15'h5200, 8);
    $display("test page done");
  endtask
  task automatic t_low_vdd();
    low_vdd <= 1'b1;
    wr(15'h5201, '{8'h77}, 1'b0);
    low_vdd <= 1'b0;
    rd(15'h5200, 2);
    $display("test low supply done");
  endtask
  task automatic t_wrap();
    logic [7:0] q[$];
    for (int i = 0; i < 66; i++) begin
      q.push_back(8'(i + 1));
    end
    wr(15'h51fa, q, 1'b1);
    rd(15'h51f8, 64);
    $display("test wrap done");
  endtask
  task automatic t_top();
    wr(15'h5000, '{8'hc3}, 1'b0);
    wr(15'h5fff, '{8'h3c}, 1'b0);
    rd(15'h5fff, 2);
    wr(15'h57ff, '{8'h5a, 8'ha5}, 1'b0);
    rd(15'h57ff, 2);
    $display("test top address done");
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    fail_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    pins = 3'h5;
    low_vdd = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_select();
    t_page();
    t_low_vdd();
    t_wrap();
    t_top();
    final_report();
  end
endmodule
